// ---- hdl/prio_regs_defs.svh ----
// constants of the interrupt priority register bank
// assumes a 32-bit apb bus with 12 address bits
`ifndef PRIO_REGS_DEFS_SVH
`define PRIO_REGS_DEFS_SVH

`define PR_ADDR_W 12
`define PR_NUM_SRC 15
`define PR_NUM_SLOT 7

// byte offsets of the seven registers
`define PR_OFS_CTRL10 12'h028
`define PR_OFS_CTRL11 12'h02c
`define PR_OFS_CTRL12 12'h030
`define PR_OFS_CTRL13 12'h034
`define PR_OFS_CTRL15 12'h03c
`define PR_OFS_CTRL16 12'h040
`define PR_OFS_CTRL18 12'h048

// slot numbers of the registers
`define PR_SLOT_CTRL10 0
`define PR_SLOT_CTRL11 1
`define PR_SLOT_CTRL12 2
`define PR_SLOT_CTRL13 3
`define PR_SLOT_CTRL15 4
`define PR_SLOT_CTRL16 5
`define PR_SLOT_CTRL18 6

// field reset value
`define PR_FIELD_RESET 3'h4

// lowest bit of each field in its register
`define PR_LSB_CMP_OUT7 12
`define PR_LSB_CMP_OUT6 8
`define PR_LSB_CMP_OUT5 4
`define PR_LSB_CAPTURE6 0
`define PR_LSB_PAR_MASTER_PORT 4
`define PR_LSB_CMP_OUT8 0
`define PR_LSB_I2C_B_MASTER 8
`define PR_LSB_I2C_B_SLAVE 4
`define PR_LSB_EXT_IRQ4 8
`define PR_LSB_EXT_IRQ3 4
`define PR_LSB_CLOCK_CALENDAR 8
`define PR_LSB_CRC_ERROR 12
`define PR_LSB_UART_B_ERROR 8
`define PR_LSB_UART_A_ERROR 4
`define PR_LSB_LOW_VOLT_DETECT 0

`endif

// ---- hdl/prio_regs_pkg.sv ----
// types of the interrupt priority register bank
// assumes nothing of its surroundings
package prio_regs_pkg;

    typedef logic [2:0] prio_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACCESS = 2'b10
    } apb_state_t;

    // index of each source in the request and level vectors
    typedef enum logic [3:0] {
        CMP_OUT7_PRIO = 4'h0,
        CMP_OUT6_PRIO = 4'h1,
        CMP_OUT5_PRIO = 4'h2,
        CAPTURE6_PRIO = 4'h3,
        PAR_MASTER_PORT_PRIO = 4'h4,
        CMP_OUT8_PRIO = 4'h5,
        I2C_B_MASTER_PRIO = 4'h6,
        I2C_B_SLAVE_PRIO = 4'h7,
        EXT_IRQ4_PRIO = 4'h8,
        EXT_IRQ3_PRIO = 4'h9,
        CLOCK_CALENDAR_PRIO = 4'ha,
        CRC_ERROR_PRIO = 4'hb,
        UART_B_ERROR_PRIO = 4'hc,
        UART_A_ERROR_PRIO = 4'hd,
        LOW_VOLT_DETECT_PRIO = 4'he
    } src_id_t;

endpackage : prio_regs_pkg

// ---- hdl/prio_field.sv ----
// one three-bit priority field
// assumes write enable and data on the same clock
`timescale 1ns/100ps
module prio_field
    import prio_regs_pkg::*;
#(
    parameter prio_regs_pkg::prio_t RESET_VAL = 3'h4
)
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire prio_regs_pkg::prio_t wdata_i,
    output prio_regs_pkg::prio_t value_o
);
    prio_t value_r;

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            value_r <= RESET_VAL;
        else if (ce_i && wr_en_i)
            value_r <= wdata_i;
    end

    assign value_o = value_r;

endmodule : prio_field

// ---- hdl/prio_gate.sv ----
// gates one source request by its priority code
// assumes the request comes from logic on the same clock
`timescale 1ns/100ps
module prio_gate
    import prio_regs_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic req_i,
    input wire prio_regs_pkg::prio_t prio_i,
    output logic req_o,
    output prio_regs_pkg::prio_t level_o
);
    logic enabled;
    logic req_r;
    prio_t level_r;

    // code zero disables, other codes are the level itself
    assign enabled = (prio_i != 3'h0);

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            req_r <= 1'b0;
            level_r <= 3'h0;
        end
        else if (ce_i)
        begin
            req_r <= req_i && enabled;
            level_r <= (req_i && enabled) ? prio_i : 3'h0;
        end
    end

    assign req_o = req_r;
    assign level_o = level_r;

endmodule : prio_gate

// ---- hdl/prio_regs.sv ----
// interrupt priority register bank with apb slave
// assumes apb master and source requests on clock_i
//
// Notes on behaviour
// - fields are three bits; 111 is level 7 highest, 001 level 1
// - a field holding 000 disables its source; no request is raised
// - unassigned bits ignore writes and read as zero
// - every field resets to 100, level 4
// - all field bits are read/write; reads return last write
// - register 10 holds cmp out 7, 6, 5 and capture 6 fields
// - register 11 holds parallel port and cmp out 8 fields
// - register 12 holds second i2c master and slave fields
// - register 13 holds external irq 4 and 3 fields
// - register 15 holds only the clock calendar field
// - register 16 holds crc error and two uart error fields
// - register 18 holds only the low voltage detect field
`include "prio_regs_defs.svh"
`timescale 1ns/100ps
module prio_regs
    import prio_regs_pkg::*;
#(
    parameter int NUM_SRC = `PR_NUM_SRC
)
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`PR_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [NUM_SRC-1:0] src_req_i,
    output logic [NUM_SRC-1:0] req_o,
    output logic [3*NUM_SRC-1:0] level_o
);
    import prio_regs_pkg::*;

    localparam int NUM_SLOT = `PR_NUM_SLOT;

    // -------------------------------------------------------------
    // field table
    // -------------------------------------------------------------
    localparam logic [`PR_ADDR_W-1:0] SLOT_OFS [NUM_SLOT] = '{
        `PR_OFS_CTRL10, `PR_OFS_CTRL11, `PR_OFS_CTRL12,
        `PR_OFS_CTRL13, `PR_OFS_CTRL15, `PR_OFS_CTRL16,
        `PR_OFS_CTRL18
    };

    localparam int FLD_SLOT [`PR_NUM_SRC] = '{
        `PR_SLOT_CTRL10, `PR_SLOT_CTRL10, `PR_SLOT_CTRL10,
        `PR_SLOT_CTRL10, `PR_SLOT_CTRL11, `PR_SLOT_CTRL11,
        `PR_SLOT_CTRL12, `PR_SLOT_CTRL12, `PR_SLOT_CTRL13,
        `PR_SLOT_CTRL13, `PR_SLOT_CTRL15, `PR_SLOT_CTRL16,
        `PR_SLOT_CTRL16, `PR_SLOT_CTRL16, `PR_SLOT_CTRL18
    };

    localparam int FLD_LSB [`PR_NUM_SRC] = '{
        `PR_LSB_CMP_OUT7, `PR_LSB_CMP_OUT6, `PR_LSB_CMP_OUT5,
        `PR_LSB_CAPTURE6, `PR_LSB_PAR_MASTER_PORT,
        `PR_LSB_CMP_OUT8, `PR_LSB_I2C_B_MASTER,
        `PR_LSB_I2C_B_SLAVE, `PR_LSB_EXT_IRQ4, `PR_LSB_EXT_IRQ3,
        `PR_LSB_CLOCK_CALENDAR, `PR_LSB_CRC_ERROR,
        `PR_LSB_UART_B_ERROR, `PR_LSB_UART_A_ERROR,
        `PR_LSB_LOW_VOLT_DETECT
    };

    // -------------------------------------------------------------
    // apb decode
    // -------------------------------------------------------------
    apb_state_t state_r;
    apb_state_t state_nxt;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [NUM_SLOT-1:0] slot_hit;
    logic addr_ok;
    logic setup_ph;
    logic wr_fire;
    logic [31:0] rd_word;
    logic [31:0] rd_mask;
    logic [31:0] regs_word [NUM_SLOT];
    logic [31:0] slot_mask [NUM_SLOT];
    prio_t fld [NUM_SRC];

    genvar s;
    generate
        for (s = 0; s < NUM_SLOT; s++)
        begin : g_slot
            assign slot_hit[s] = (paddr_i == SLOT_OFS[s]);
        end
    endgenerate

    assign addr_ok = |slot_hit;
    assign setup_ph = psel_i && !penable_i;
    assign wr_fire = psel_i && penable_i && pwrite_i &&
        (state_r == ST_ACCESS) && addr_ok;
    assign state_nxt = setup_ph ? ST_ACCESS : ST_IDLE;

    // -------------------------------------------------------------
    // readback words
    // -------------------------------------------------------------
    // bits outside the field table stay zero on read
    always_comb
    begin
        for (int k = 0; k < NUM_SLOT; k++)
        begin
            regs_word[k] = 32'h0;
            slot_mask[k] = 32'h0;
            for (int i = 0; i < NUM_SRC; i++)
            begin
                if (FLD_SLOT[i] == k)
                begin
                    regs_word[k][FLD_LSB[i] +: 3] = fld[i];
                    slot_mask[k][FLD_LSB[i] +: 3] = 3'h7;
                end
            end
        end
    end

    always_comb
    begin
        rd_word = 32'h0;
        rd_mask = 32'h0;
        for (int k = 0; k < NUM_SLOT; k++)
        begin
            if (slot_hit[k])
            begin
                rd_word = rd_word | regs_word[k];
                rd_mask = rd_mask | slot_mask[k];
            end
        end
    end

    // -------------------------------------------------------------
    // apb slave state
    // -------------------------------------------------------------
    // read data and error are caught in the setup cycle so that
    // every bus output comes from a flip-flop; no wait states
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state_r <= ST_IDLE;
        else if (ce_i)
            state_r <= state_nxt;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end
        else if (ce_i)
        begin
            prdata_r <= (setup_ph && !pwrite_i) ? rd_word : 32'h0;
            pslverr_r <= setup_ph && !addr_ok;
        end
    end

    always_comb
    begin
        case (state_r)
            ST_ACCESS: pready_o = 1'b1;
            ST_IDLE: pready_o = 1'b0;
            default: pready_o = 1'b0;
        endcase
    end

    assign prdata_o = prdata_r;
    assign pslverr_o = pslverr_r;

    // -------------------------------------------------------------
    // fields and request gates
    // -------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < NUM_SRC; i++)
        begin : g_src
            logic wr_en;
            prio_t lvl;

            // byte lane of the field must be strobed
            assign wr_en = wr_fire && slot_hit[FLD_SLOT[i]] &&
                pstrb_i[FLD_LSB[i] / 8];

            prio_field #(
                .RESET_VAL(`PR_FIELD_RESET)
            ) u_field (
                .clock_i(clock_i),
                .resetn_i(resetn_i),
                .ce_i(ce_i),
                .wr_en_i(wr_en),
                .wdata_i(pwdata_i[FLD_LSB[i] +: 3]),
                .value_o(fld[i])
            );

            prio_gate u_gate (
                .clock_i(clock_i),
                .resetn_i(resetn_i),
                .ce_i(ce_i),
                .req_i(src_req_i[i]),
                .prio_i(fld[i]),
                .req_o(req_o[i]),
                .level_o(lvl)
            );

            assign level_o[3*i +: 3] = lvl;
        end
    endgenerate

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    logic wrote_r;
    logic [31:0] mask_r;

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wrote_r <= 1'b0;
            mask_r <= 32'h0;
        end
        else if (ce_i)
        begin
            if (wr_fire)
                wrote_r <= 1'b1;
            if (setup_ph)
                mask_r <= rd_mask;
        end
    end

    generate
        for (i = 0; i < NUM_SRC; i++)
        begin : g_chk
            property p_reset_field;
                !wrote_r |-> fld[i] == 3'h4;
            endproperty
            a_reset_field: assert property (p_reset_field)
                else $error("field left its reset value unwritten");

            property p_disabled;
                (ce_i && fld[i] == 3'h0) |=> !req_o[i];
            endproperty
            a_disabled: assert property (p_disabled)
                else $error("disabled source raised a request");

            property p_level;
                (ce_i && src_req_i[i] && fld[i] != 3'h0)
                    |=> req_o[i] && level_o[3*i +: 3] == $past(fld[i]);
            endproperty
            a_level: assert property (p_level)
                else $error("level differs from priority code");

            property p_top_level;
                (ce_i && src_req_i[i] && fld[i] == 3'h7)
                    |=> level_o[3*i +: 3] == 3'h7;
            endproperty
            a_top_level: assert property (p_top_level)
                else $error("code 111 did not give level 7");
        end
    endgenerate

    property p_write_read;
        (wr_fire && ce_i && pstrb_i == 4'hf) |=>
            rd_word_of($past(slot_hit)) ==
            ($past(pwdata_i) & $past(rd_mask));
    endproperty
    a_write_read: assert property (p_write_read)
        else $error("register did not hold the written value");

    property p_unimpl_zero;
        (pready_o && psel_i && !pwrite_i && !pslverr_o)
            |-> (prdata_o & ~mask_r) == 32'h0;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unassigned bit read as one");

    property p_ctrl10;
        regs_word[0] == {17'h0, fld[0], 1'b0, fld[1], 1'b0,
            fld[2], 1'b0, fld[3]};
    endproperty
    a_ctrl10: assert property (p_ctrl10)
        else $error("register 10 layout wrong");

    property p_ctrl11;
        regs_word[1] == {25'h0, fld[4], 1'b0, fld[5]};
    endproperty
    a_ctrl11: assert property (p_ctrl11)
        else $error("register 11 layout wrong");

    property p_ctrl12;
        regs_word[2] == {21'h0, fld[6], 1'b0, fld[7], 4'h0};
    endproperty
    a_ctrl12: assert property (p_ctrl12)
        else $error("register 12 layout wrong");

    property p_ctrl13;
        regs_word[3] == {21'h0, fld[8], 1'b0, fld[9], 4'h0};
    endproperty
    a_ctrl13: assert property (p_ctrl13)
        else $error("register 13 layout wrong");

    property p_ctrl15;
        regs_word[4] == {21'h0, fld[10], 8'h0};
    endproperty
    a_ctrl15: assert property (p_ctrl15)
        else $error("register 15 layout wrong");

    property p_ctrl16;
        regs_word[5] == {17'h0, fld[11], 1'b0, fld[12], 1'b0,
            fld[13], 4'h0};
    endproperty
    a_ctrl16: assert property (p_ctrl16)
        else $error("register 16 layout wrong");

    property p_ctrl18;
        regs_word[6] == {29'h0, fld[14]};
    endproperty
    a_ctrl18: assert property (p_ctrl18)
        else $error("register 18 layout wrong");

    property p_ready;
        (ce_i && psel_i && !penable_i) |=> pready_o;
    endproperty
    a_ready: assert property (p_ready)
        else $error("access phase without ready");

    function automatic logic [31:0] rd_word_of(
        input logic [NUM_SLOT-1:0] hit
    );
        logic [31:0] w;
        w = 32'h0;
        for (int k = 0; k < NUM_SLOT; k++)
        begin
            if (hit[k])
                w = w | regs_word[k];
        end
        return w;
    endfunction : rd_word_of

    // -------------------------------------------------------------
    // covers
    // -------------------------------------------------------------
    property p_cov_write;
        wr_fire && ce_i;
    endproperty
    c_cov_write: cover property (p_cov_write);

    property p_cov_read;
        pready_o && psel_i && !pwrite_i && !pslverr_o;
    endproperty
    c_cov_read: cover property (p_cov_read);

    property p_cov_err;
        pready_o && pslverr_o;
    endproperty
    c_cov_err: cover property (p_cov_err);

    property p_cov_masked;
        ce_i && src_req_i[0] && fld[0] == 3'h0;
    endproperty
    c_cov_masked: cover property (p_cov_masked);

endmodule : prio_regs

// ---- test/test_interrupt_priority_regs_b.sv ----
// self-checking bench of the interrupt priority register bank
// assumes apb answers come one cycle after setup and that requests
// are gated one cycle after they are sampled
`include "prio_regs_defs.svh"
`timescale 1ns/100ps
module test_interrupt_priority_regs_b;
    import prio_regs_pkg::*;

    logic clock_i;
    logic resetn_i;
    logic ce_i;
    logic psel_i;
    logic penable_i;
    logic pwrite_i;
    logic [`PR_ADDR_W-1:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [3:0] pstrb_i;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [`PR_NUM_SRC-1:0] src_req_i;
    logic [`PR_NUM_SRC-1:0] req_o;
    logic [3*`PR_NUM_SRC-1:0] level_o;
    logic [`PR_NUM_SRC-1:0] er_last;
    logic [3*`PR_NUM_SRC-1:0] el_last;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int checks = 0;
    int fld [`PR_NUM_SRC];
    // register slot and field lsb of every source
    int slot_of [`PR_NUM_SRC] = '{0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 5, 5,
        5, 6};
    int lsb_of [`PR_NUM_SRC] = '{12, 8, 4, 0, 4, 0, 8, 4, 8, 4, 8, 12, 8,
        4, 0};
    // seven mapped offsets, then two holes of the map
    logic [`PR_ADDR_W-1:0] ofs [9] = '{`PR_OFS_CTRL10, `PR_OFS_CTRL11,
        `PR_OFS_CTRL12, `PR_OFS_CTRL13, `PR_OFS_CTRL15, `PR_OFS_CTRL16,
        `PR_OFS_CTRL18, 12'h038, 12'h044};

    prio_regs #(.NUM_SRC(`PR_NUM_SRC)) DUT (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .src_req_i(src_req_i),
        .req_o(req_o),
        .level_o(level_o)
    );

    initial
    begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [63:0] seen,
        input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    function automatic logic [31:0] exp_reg(input int s);
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < `PR_NUM_SRC; i++)
            if (slot_of[i] == s)
                v |= 32'(fld[i]) << lsb_of[i];
        return v;
    endfunction : exp_reg

    // one apb transfer; psel stays up when another transfer follows
    task automatic xfer(input logic wr, input int a, input logic [31:0] wd,
        input logic [3:0] st, input logic last);
        int n;
        n = 0;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= ofs[a];
        pwdata_i <= wd;
        pstrb_i <= st;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clock_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 50);
        rd = prdata_o;
        err = pslverr_o;
        chk("pready", pready_o, 1'b1);
        chk("pslverr", err, a > 6);
        chk("prdata", rd, (wr || a > 6) ? 32'h0 : exp_reg(a));
        if (wr && a < 7)
            for (int i = 0; i < `PR_NUM_SRC; i++)
                if (slot_of[i] == a && st[lsb_of[i] / 8])
                    fld[i] = int'(wd[lsb_of[i] +: 3]);
        if (last)
        begin
            psel_i <= 1'b0;
            penable_i <= 1'b0;
            // one idle edge, so psel is seen low before a following setup drives it high again
            @(posedge clock_i);
            chk("pready idle", pready_o, 1'b0);
            chk("prdata idle", prdata_o, 32'h0);
            chk("pslverr idle", pslverr_o, 1'b0);
        end
    endtask : xfer

    task automatic read_all();
        for (int s = 0; s < 7; s++)
            xfer(1'b0, s, 32'h0, 4'h0, s == 6);
    endtask : read_all

    // drives requests and checks gating one cycle later
    task automatic chk_req(input logic [`PR_NUM_SRC-1:0] src);
        er_last = '0;
        el_last = '0;
        for (int i = 0; i < `PR_NUM_SRC; i++)
            if (src[i] && fld[i] != 0)
            begin
                er_last[i] = 1'b1;
                el_last[3*i +: 3] = 3'(fld[i]);
            end
        @(posedge clock_i);
        src_req_i <= src;
        @(posedge clock_i);
        @(negedge clock_i);
        chk("req", req_o, er_last);
        chk("level", level_o, el_last);
    endtask : chk_req

    task automatic do_reset();
        resetn_i <= 1'b0;
        repeat (10) @(posedge clock_i);
        chk("pready in reset", pready_o, 1'b0);
        chk("req in reset", req_o, '0);
        resetn_i <= 1'b1;
        for (int i = 0; i < `PR_NUM_SRC; i++)
            fld[i] = 4;
    endtask : do_reset

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        resetn_i = 1'b0;
        ce_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = '0;
        pwdata_i = 32'h0;
        pstrb_i = 4'h0;
        src_req_i = '0;
        void'($urandom(32'h5edc2268));
        do_reset();
        read_all();
        chk_req('1);
        $display("test reset_values done");
        // every code in every field, top bit of each nibble written as one
        for (int c = 0; c < 8; c++)
        begin
            for (int s = 0; s < 7; s++)
                xfer(1'b1, s, {8{1'b1, 3'(c)}}, 4'hf, s == 6);
            chk_req('1);
            read_all();
        end
        $display("test code_sweep done");
        for (int k = 0; k < 300; k++)
        begin
            xfer($urandom % 2, $urandom % 9, $urandom, 4'($urandom),
                k % 10 == 9 || $urandom % 2);
            if (k % 10 == 9)
                chk_req(15'($urandom));
        end
        read_all();
        $display("test random_access done");
        // a stopped clock enable freezes the request path
        chk_req('1);
        @(posedge clock_i);
        ce_i <= 1'b0;
        src_req_i <= '0;
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        chk("frozen req", req_o, er_last);
        chk("frozen level", level_o, el_last);
        @(posedge clock_i);
        ce_i <= 1'b1;
        chk_req(15'($urandom));
        $display("test clock_enable done");
        @(posedge clock_i);
        do_reset();
        read_all();
        chk_req('1);
        $display("test second_reset done");
        report_and_stop();
    end

    initial
    begin
        repeat (50000) @(posedge clock_i);
        n_mismatch++;
        report_and_stop();
    end
endmodule : test_interrupt_priority_regs_b
